// ==== include/pts_consts.svh ====
/*
  Constants for the PWM timebase selector: register offsets, field layout,
  reset values and select codes.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

// Byte offsets on the Avalon-MM slave (word aligned)
`define PTS_OFS_SEL      4'h0
`define PTS_OFS_STAT     4'h4

// Reset value of the selection register
`define PTS_SEL_RST      8'h00

// Width of one channel select field
`define PTS_FLD_W        2

// Select codes of one field
`define PTS_CODE_TMR2    2'h0
`define PTS_CODE_TMR4    2'h1
`define PTS_CODE_TMR6    2'h2
`define PTS_CODE_RSV     2'h3

// Index of each timer on the timer array of a channel mux
`define PTS_IDX_TMR2     0
`define PTS_IDX_TMR4     1
`define PTS_IDX_TMR6     2

`endif

// ==== include/pts_pkg.sv ====
/*
  Types shared by the PWM timebase selector and its channel mux.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pts_pkg;

  typedef logic [7:0]  pts_byte_t;   // One 8-bit register or count
  typedef logic [1:0]  pts_sel_t;    // One channel select field
  typedef logic [31:0] pts_word_t;   // Avalon data word

  // Everything one timer hands to a PWM channel
  typedef struct packed {
    pts_byte_t cnt;                  // Running timer count
    logic      match;                // Period match strobe
    logic      post;                 // Postscaled output strobe
  } pts_tmr_s;

endpackage

// ==== include/pts_mux_if.sv ====
/*
  Carrier between the selector top and one channel mux: the select field,
  the three candidate timers and the routed timebase.
  Assumes the top drives sel and tmr, the mux drives out.
*/
`timescale 1ns/1ps
interface pts_mux_if;
  import pts_pkg::*;

  pts_sel_t sel;                     // Channel select field
  pts_tmr_s tmr [3];                 // Timers 2, 4 and 6 in that order
  pts_tmr_s out;                     // Timebase routed to the channel

  modport src (output sel, output tmr, input out);
  modport mux (input sel, input tmr, output out);
endinterface

// ==== verilog/pts_chan_mux.sv ====
/*
  Three-way timebase mux for one PWM channel, registered on the output.
  Assumes the timers are synchronous to mclk_i and the select is stable
  from the register of the top.
*/
`timescale 1ns/1ps
`include "pts_consts.svh"

module pts_chan_mux (
  input wire logic mclk_i,           // System clock, 40 MHz
  input wire logic rstn_i,           // Async reset, active low
  pts_mux_if.mux   mx                // Select, timers in, timebase out
);
  import pts_pkg::*;

  // Combinational pick of the chosen timer
  pts_tmr_s pick;                    // Selected timer this cycle

  // Reserved code routes nothing: channel sees a dead timebase
  assign pick =
    (mx.sel == `PTS_CODE_TMR2) ? mx.tmr[`PTS_IDX_TMR2] :
    (mx.sel == `PTS_CODE_TMR4) ? mx.tmr[`PTS_IDX_TMR4] :
    (mx.sel == `PTS_CODE_TMR6) ? mx.tmr[`PTS_IDX_TMR6] :
    '0;

  // Output flop: one cycle of latency, but no glitches on a select change
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mx.out <= '0;
    end
    else
    begin
      mx.out <= pick;
    end
  end

endmodule

// ==== verilog/pts_timebase_sel.sv ====
/*
  PWM timebase selector: one 8-bit select register on an Avalon-MM slave,
  four channel muxes that route timer 2, 4 or 6 to each PWM channel.
  Assumes the timers and the PWM channels sit outside and run on mclk_i.
*/
//
// Functional notes
// - Channel four: bits 7-6 pick timer 2/4/6
// - Channel three: bits 5-4 pick timer 2/4/6
// - Channel two: bits 3-2 pick timer 2/4/6
// - Channel one: bits 1-0 pick timer 2/4/6
`timescale 1ns/1ps
`include "pts_consts.svh"

module pts_timebase_sel (
  input  wire logic            mclk_i,            // System clock, 40 MHz
  input  wire logic            rstn_i,            // Async reset, low
  input  wire logic [3:0]      avs_address_i,     // Byte address
  input  wire logic            avs_read_i,        // Read request
  input  wire logic            avs_write_i,       // Write request
  input  wire pts_pkg::pts_word_t avs_writedata_i, // Write data
  input  wire logic [3:0]      avs_byteenable_i,  // Byte lanes
  output pts_pkg::pts_word_t   avs_readdata_o,    // Read data
  output logic                 avs_waitrequest_o, // Stall the master
  input  wire pts_pkg::pts_byte_t tmr2_cnt_i,     // Timer 2 count
  input  wire logic            tmr2_match_i,      // Timer 2 period match
  input  wire logic            tmr2_post_i,       // Timer 2 postscaled
  input  wire pts_pkg::pts_byte_t tmr4_cnt_i,     // Timer 4 count
  input  wire logic            tmr4_match_i,      // Timer 4 period match
  input  wire logic            tmr4_post_i,       // Timer 4 postscaled
  input  wire pts_pkg::pts_byte_t tmr6_cnt_i,     // Timer 6 count
  input  wire logic            tmr6_match_i,      // Timer 6 period match
  input  wire logic            tmr6_post_i,       // Timer 6 postscaled
  output logic [31:0]          chan_cnt_o,        // Count, 8 bits a chan
  output logic [3:0]           chan_match_o,      // Match, bit per chan
  output logic [3:0]           chan_post_o,       // Postscale, per chan
  output pts_pkg::pts_byte_t   sel_o              // Select register
);
  import pts_pkg::*;

  // Pull one channel's field out of the select register
  function automatic pts_sel_t sel_field(input pts_byte_t r,
                                         input int unsigned ch);
    sel_field = r[ch*`PTS_FLD_W +: `PTS_FLD_W];
  endfunction

  // Register and bus state
  pts_byte_t sel_r;                  // Timebase select register
  pts_byte_t sel_nxt;                // Its next value
  logic      ack_r;                  // Second cycle of an access
  pts_word_t rdata_r;                // Read data held for the master
  pts_word_t rdata_nxt;              // Its next value

  // Bus decode
  wire       req      = avs_read_i | avs_write_i;     // Access pending
  wire       hit_sel  = avs_address_i == `PTS_OFS_SEL;  // Select reg
  wire       hit_stat = avs_address_i == `PTS_OFS_STAT; // Status reg
  wire       wr_sel   = avs_write_i & ack_r & hit_sel
                        & avs_byteenable_i[0];        // Commit a write
  wire [3:0] rsv_flag;               // Channel holds the reserved code

  // Timer bundles, shared by every channel mux
  wire pts_tmr_s tmr2 = '{cnt: tmr2_cnt_i, match: tmr2_match_i,
                          post: tmr2_post_i};         // Timer 2
  wire pts_tmr_s tmr4 = '{cnt: tmr4_cnt_i, match: tmr4_match_i,
                          post: tmr4_post_i};         // Timer 4
  wire pts_tmr_s tmr6 = '{cnt: tmr6_cnt_i, match: tmr6_match_i,
                          post: tmr6_post_i};         // Timer 6

  // One wait state on every access, so the answer comes at edge two
  assign avs_waitrequest_o = req & ~ack_r;

  // Unmapped addresses read zero; writes there are acknowledged, dropped
  assign rdata_nxt =
    hit_sel  ? {24'h000000, sel_r} :
    hit_stat ? {28'h0000000, rsv_flag} :
    32'h00000000;

  // Only lane 0 carries the register, upper lanes are ignored
  assign sel_nxt = wr_sel ? avs_writedata_i[7:0] : sel_r;

  assign avs_readdata_o = rdata_r;
  assign sel_o          = sel_r;

  // Access handshake: ack toggles high for the answering cycle
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read data captured in the stall cycle, stands at the answer edge
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_r <= 32'h00000000;
    end
    else if (avs_read_i & ~ack_r)
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // Select register: every reset brings all channels back to timer 2
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sel_r <= `PTS_SEL_RST;
    end
    else
    begin
      sel_r <= sel_nxt;
    end
  end

  // Four channel muxes; channel g+1 uses field g of the register
  for (genvar g = 0; g < 4; g++)
  begin : g_chan
    pts_mux_if mx ();                // Carrier to this channel's mux

    // Field g steers channel g+1 (fields 3..0 are chans 4..1)
    assign mx.sel = sel_field(sel_r, g);
    assign mx.tmr[`PTS_IDX_TMR2] = tmr2;
    assign mx.tmr[`PTS_IDX_TMR4] = tmr4;
    assign mx.tmr[`PTS_IDX_TMR6] = tmr6;

    // Reserved code is visible to software in the status register
    assign rsv_flag[g] = mx.sel == `PTS_CODE_RSV;

    pts_chan_mux u_mux (
      .mclk_i (mclk_i),
      .rstn_i (rstn_i),
      .mx     (mx.mux)
    );

    // Outputs come straight from the mux flops
    assign chan_cnt_o[g*8 +: 8] = mx.out.cnt;
    assign chan_match_o[g]      = mx.out.match;
    assign chan_post_o[g]       = mx.out.post;
  end

  // Routing check: output follows the timer the field named last cycle.
  // Sampled reset gates the start: at the release edge the mux flops
  // are still held, so that edge must not open an attempt.
  property p_route(pts_sel_t s, pts_byte_t cnt, logic m, logic p);
    @(posedge mclk_i) disable iff (!rstn_i)
    ((rstn_i && s == `PTS_CODE_TMR2) |=>
       cnt == $past(tmr2_cnt_i) && m == $past(tmr2_match_i)
       && p == $past(tmr2_post_i)) and
    ((rstn_i && s == `PTS_CODE_TMR4) |=>
       cnt == $past(tmr4_cnt_i) && m == $past(tmr4_match_i)
       && p == $past(tmr4_post_i)) and
    ((rstn_i && s == `PTS_CODE_TMR6) |=>
       cnt == $past(tmr6_cnt_i) && m == $past(tmr6_match_i)
       && p == $past(tmr6_post_i)) and
    ((rstn_i && s == `PTS_CODE_RSV) |=> cnt == 8'h00 && !m && !p);
  endproperty

  a_chan4_route: assert property (p_route(sel_r[7:6], chan_cnt_o[31:24],
    chan_match_o[3], chan_post_o[3]))
    else $error("channel four routed from wrong timer");

  a_chan3_route: assert property (p_route(sel_r[5:4], chan_cnt_o[23:16],
    chan_match_o[2], chan_post_o[2]))
    else $error("channel three routed from wrong timer");

  a_chan2_route: assert property (p_route(sel_r[3:2], chan_cnt_o[15:8],
    chan_match_o[1], chan_post_o[1]))
    else $error("channel two routed from wrong timer");

  a_chan1_route: assert property (p_route(sel_r[1:0], chan_cnt_o[7:0],
    chan_match_o[0], chan_post_o[0]))
    else $error("channel one routed from wrong timer");

  // Steps of a register write and a register read
  sequence s_sel_write;
    avs_write_i && hit_sel && avs_byteenable_i[0] && !avs_waitrequest_o;
  endsequence

  sequence s_sel_read_start;
    avs_read_i && hit_sel && avs_waitrequest_o;
  endsequence

  a_sel_write_takes: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_sel_write |=> sel_r == $past(avs_writedata_i[7:0]))
    else $error("select write not stored");

  a_sel_read_back: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_sel_read_start ##1 !avs_waitrequest_o |->
      avs_readdata_o == {24'h000000, $past(sel_r)})
    else $error("select readback mismatch");

  a_bus_one_wait: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("access not answered on second edge");

  a_sel_holds: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !$past(wr_sel) |-> $stable(sel_r))
    else $error("select changed without a write");

  // Every reset leaves the register at zero: all channels on timer 2
  a_sel_reset_zero: assert property (@(posedge mclk_i)
    $rose(rstn_i) |-> sel_r == `PTS_SEL_RST)
    else $error("select not cleared by reset");

  // Channel outputs stay dead until the first sample after reset
  a_chan_reset_zero: assert property (@(posedge mclk_i)
    $rose(rstn_i) |-> chan_cnt_o == 32'h00000000 && chan_match_o == 4'h0
      && chan_post_o == 4'h0)
    else $error("channel outputs not cleared by reset");

  // Status read reports which fields hold the reserved code
  a_stat_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (avs_read_i && hit_stat && avs_waitrequest_o) |=>
      avs_readdata_o == {28'h0000000, $past(rsv_flag)})
    else $error("status readback mismatch");

endmodule

// ==== test/pts_tb.sv ====
/*
  Self-checking bench for the PWM timebase selector: register access over
  Avalon-MM, channel routing for every select code, reset behaviour.
  Assumes the design files and pts_pkg are compiled before this file.
*/
`timescale 1ns/1ps
module tb;
  import pts_pkg::*;

  logic        mclk_i = 1'b0;    // 40 MHz clock
  logic        rstn_i = 1'b0;    // Reset, active low
  logic [3:0]  adr    = 4'h0;    // Bus address
  logic        rd     = 1'b0;    // Read request
  logic        wr     = 1'b0;    // Write request
  pts_word_t   wdat   = '0;      // Write data
  logic [3:0]  be     = 4'hf;    // Byte lanes
  pts_word_t   rdat;             // Read data
  logic        wait_o;           // Wait request
  logic [31:0] c_cnt;            // Routed counts
  logic [3:0]  c_mat;            // Routed matches
  logic [3:0]  c_pst;            // Routed postscaled
  pts_byte_t   sel_o;            // Register copy
  pts_word_t   q;                // Last read value
  int          num_errors = 0;   // Mismatches
  int          n_tests    = 0;   // Comparisons
  // Distinct timer values so a wrong route always shows
  pts_byte_t   t_cnt [3] = '{8'h12, 8'h34, 8'h56};
  logic [2:0]  t_mat = 3'b101;   // Timers 6,4,2 from msb
  logic [2:0]  t_pst = 3'b110;

  always #12.5 mclk_i = ~mclk_i; // 25 ns period

  pts_timebase_sel DUT (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o),
    .tmr2_cnt_i(t_cnt[0]), .tmr2_match_i(t_mat[0]), .tmr2_post_i(t_pst[0]),
    .tmr4_cnt_i(t_cnt[1]), .tmr4_match_i(t_mat[1]), .tmr4_post_i(t_pst[1]),
    .tmr6_cnt_i(t_cnt[2]), .tmr6_match_i(t_mat[2]), .tmr6_post_i(t_pst[2]),
    .chan_cnt_o(c_cnt), .chan_match_o(c_mat), .chan_post_o(c_pst),
    .sel_o(sel_o));

  // Verdict in one place, also reached by a spent timeout
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input pts_word_t d, input logic [3:0] b);
    int n;
    @(posedge mclk_i);
    adr  <= a;
    wdat <= d;
    be   <= b;
    rd   <= !w;
    wr   <= w;
    // Read at the rising edge, before that edge's updates land
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk_i);
      if (wait_o === 1'b0)
        break;
    end
    if (n == 50)
    begin
      num_errors++;
      report_and_stop();
    end
    // Answer edge: data taken and request dropped at this edge only
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Expected channel outputs {post, match, counts} for a select byte
  function automatic logic [39:0] exp_ch(input pts_byte_t s);
    logic [39:0] e;
    int          c;
    e = '0;
    for (int g = 0; g < 4; g++)
    begin
      c = s[2*g +: 2];
      if (c < 3)                 // Reserved code gives zeros
      begin
        e[8*g +: 8] = t_cnt[c];
        e[32 + g]   = t_mat[c];
        e[36 + g]   = t_pst[c];
      end
    end
    return e;
  endfunction

  // Outputs settle one edge after the answer edge; checked after two
  task automatic check_ch(input pts_byte_t s);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    check({c_pst, c_mat, c_cnt}, exp_ch(s));
    check({32'h0, sel_o}, {32'h0, s});
  endtask

  // Every code on every channel, then the reserved code everywhere
  pts_byte_t pats [4] = '{8'h24, 8'h49, 8'h92, 8'hff};

  initial
  begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    bus(1'b0, 4'h0, '0, 4'hf);
    check(q, 40'h0);
    check_ch(8'h00);
    foreach (pats[i])
    begin
      bus(1'b1, 4'h0, {24'hffffff, pats[i]}, 4'h1);
      check_ch(pats[i]);
      bus(1'b0, 4'h0, '0, 4'hf);
      check(q, {32'h0, pats[i]});
    end
    // Lane off and unmapped writes must leave the register alone
    bus(1'b1, 4'h0, 32'h0000_0055, 4'he);
    bus(1'b1, 4'h8, 32'h0000_0055, 4'hf);
    bus(1'b0, 4'h0, '0, 4'hf);
    check(q, 40'hff);
    bus(1'b0, 4'h8, '0, 4'hf);
    check(q, 40'h0);
    // Every field now holds the reserved code
    bus(1'b0, 4'h4, '0, 4'hf);
    check(q, 40'hf);
    // New timer values must reach the channels one sample later
    bus(1'b1, 4'h0, 32'h0000_0024, 4'h1);
    t_cnt[1] <= 8'h78;
    t_mat    <= 3'b010;
    t_pst    <= 3'b001;
    check_ch(8'h24);
    // Second reset in mid-run clears everything back to timer 2
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    check_ch(8'h00);
    bus(1'b0, 4'h0, '0, 4'hf);
    check(q, 40'h0);
    report_and_stop();
  end
endmodule
